// file: rtl/dome_clamp_interlock.sv
// Implementation choices: the Avalon-MM slave port and the register offsets.
`timescale 1ns/1ps
// What this block does
// - service position: pad lock, subsystem reset or emergency stop sets the clamp latch
// - computer position: host lock, watchdog, software stop, reset or estop set latch
// - lock position holds the clamp latch set unconditionally
// - latch stays set after its set condition goes away until released
// - clear only with no set active; service clears on pad unlock button
// - computer position clears on host unlatch request with watchdog not expired
// - inverter enable needs estop clear, brakes released, pad lock not pressed
// - computer position also needs no host lock, no watchdog, no software stop
// - any unmet enable condition drives inverter enable to disabled level
// - warning while a pad direction button is pressed and clamp is engaged
// - active-low release output low only while the latch is cleared
// - key decode: service low, computer low, both high means lock
// - pressure sense high means clamp disengaged, low means engaged
// - host halt low only when neither watchdog expiry nor software stop
module dome_clamp_interlock
  import dci_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic key_service_pos_n,
  input wire logic key_computer_pos_n,
  input wire logic pad_lock_n,
  input wire logic pad_unlock_n,
  input wire logic pad_forward_n,
  input wire logic pad_reverse_n,
  input wire logic host_lock_request,
  input wire logic host_unlatch_request,
  input wire logic host_watchdog_expired,
  input wire logic subsystem_reset,
  input wire logic estop_n,
  input wire logic brakes_released,
  input wire logic hold_pressure_sense,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic hold_release_n,
  output logic inverter_enable,
  output logic operator_warning,
  output logic host_halt,
  output logic irq
);
  logic [DCI_SYNC_W-1:0] pinRaw;
  logic [DCI_SYNC_W-1:0] pinSync;
  logic keySvcN, keyCompN, padLockN, padUnlockN, padFwdN, padRevN;
  logic hostLock, hostUnlatch, hostWdog, subReset, estopN, brakesRel;
  dci_pos_t keyPos;
  logic swStop;
  logic haltCond;
  logic setCond;
  logic clrCond;
  logic latch;
  logic next_latch;
  logic invEnComb;
  logic warnComb;
  logic invEnQ, warnQ, haltQ;
  logic next_invEnQ, next_warnQ, next_haltQ;
  logic [DCI_EV_W-1:0] status;
  logic [DCI_EV_W-1:0] next_status;
  logic [DCI_EV_W-1:0] mask;
  logic [DCI_EV_W-1:0] next_mask;
  logic next_swStop;
  logic [DCI_EV_W-1:0] events;
  logic rdPending;
  logic next_rdPending;
  logic [31:0] next_readdata;
  logic [31:0] rdMux;
  // pressure sense is kept out of the bundle: it feeds only the warning, and its
  // reset level must read as clamp disengaged
  logic pressMeta;
  logic pressSync;
  logic next_pressMeta;
  logic next_pressSync;
  // read handshake helpers: a read is taken once, on its first cycle
  logic rdAccept;
  logic statusRdClr;

  // all pins cross into core_clk through two flops; reset loads every synchronised pin high
  assign pinRaw = {key_service_pos_n, key_computer_pos_n, pad_lock_n, pad_unlock_n, pad_forward_n,
    pad_reverse_n, host_lock_request, host_unlatch_request, host_watchdog_expired, subsystem_reset,
    estop_n, brakes_released};

  dci_sync #(.W(DCI_SYNC_W)) u_sync (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .async_in(pinRaw),
    .rst_val('1),
    .sync_out(pinSync)
  );

  assign {keySvcN, keyCompN, padLockN, padUnlockN, padFwdN, padRevN,
    hostLock, hostUnlatch, hostWdog, subReset, estopN, brakesRel} = pinSync;

  // key switch decode; both low is treated as lock for safety
  always_comb
  begin
    if (!keySvcN && keyCompN)
      keyPos = DCI_POS_SERVICE;
    else if (keySvcN && !keyCompN)
      keyPos = DCI_POS_COMPUTER;
    else
      keyPos = DCI_POS_LOCK;
  end

  // halt combines watchdog expiry and the software stop bit
  assign haltCond = hostWdog | swStop;

  // latch set and clear terms per key position
  always_comb
  begin
    setCond = 1'b0;
    clrCond = 1'b0;
    case (keyPos)
      DCI_POS_SERVICE:
      begin
        setCond = !padLockN || subReset || !estopN;
        clrCond = !padUnlockN;
      end
      DCI_POS_COMPUTER:
      begin
        setCond = hostLock || haltCond || subReset || !estopN;
        clrCond = hostUnlatch && !hostWdog;
      end
      DCI_POS_LOCK:
        setCond = 1'b1;
      default:
        setCond = 1'b1;
    endcase
  end

  // set dominates clear; latch holds otherwise
  always_comb
  begin
    if (setCond)
      next_latch = 1'b1;
    else if (clrCond)
      next_latch = 1'b0;
    else
      next_latch = latch;
  end

  // inverter enable and warning terms; pressure low means clamp engaged
  always_comb
  begin
    invEnComb = estopN && brakesRel && padLockN && (keyPos != DCI_POS_LOCK);
    if (keyPos == DCI_POS_COMPUTER)
      invEnComb = invEnComb && !hostLock && !hostWdog && !swStop;
    warnComb = (!padFwdN || !padRevN) && !pressSync;
  end

  // pressure sense crosses on its own flop pair; its reset level reads as disengaged,
  // so leaving reset never raises a false warning
  always_comb
  begin
    next_pressMeta = hold_pressure_sense;
    next_pressSync = pressMeta;
  end

  // only the second flop is read by logic; the first may be metastable
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      pressMeta <= 1'b1;
      pressSync <= 1'b1;
    end
    else
    begin
      pressMeta <= next_pressMeta;
      pressSync <= next_pressSync;
    end
  end

  // clamp latch; reset leaves the clamp engaged, the safe side, so a set
  // condition present while in reset is never lost
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      latch <= DCI_LATCH_RST;
    else
      latch <= next_latch;
  end

  // registered outputs; default (disabled) whenever a condition drops
  // halt is reported in service position too, where it does not touch the latch
  always_comb
  begin
    next_invEnQ = invEnComb;
    next_warnQ = warnComb;
    next_haltQ = haltCond;
  end

  // output flops add one edge of latency but keep decode glitches off the pins
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      invEnQ <= 1'b0;
      warnQ <= 1'b0;
      haltQ <= 1'b0;
    end
    else
    begin
      invEnQ <= next_invEnQ;
      warnQ <= next_warnQ;
      haltQ <= next_haltQ;
    end
  end

  // events: latch edges, warning rise, inverter enable drop
  // each is a one-cycle pulse; the status register makes it sticky
  always_comb
  begin
    events = '0;
    events[DCI_EV_LATCH_SET] = next_latch && !latch;
    events[DCI_EV_LATCH_CLR] = !next_latch && latch;
    events[DCI_EV_WARN] = next_warnQ && !warnQ;
    events[DCI_EV_INV_DROP] = !next_invEnQ && invEnQ;
  end

  // a read is taken on its first cycle only; taking it again in the wait cycle
  // would clear the status register a second time and lose events
  assign rdAccept = avs_read && !rdPending;
  assign statusRdClr = rdAccept && (avs_address == DCI_OFS_STATUS);

  // sticky status, one bit per event; an event in the clearing cycle survives the clear
  for (genvar i = 0; i < DCI_EV_W; i++)
  begin : g_status
    assign next_status[i] = (status[i] && !statusRdClr) || events[i];
  end

  // status register
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      status <= '0;
    else
      status <= next_status;
  end

  // avalon read mux; live bits show registered state, so they trail the pins
  // by the synchroniser delay plus one edge, the key position by the synchroniser delay alone
  always_comb
  begin
    case (avs_address)
      DCI_OFS_STATUS: rdMux = {{(32-DCI_EV_W){1'b0}}, status};
      DCI_OFS_MASK: rdMux = {{(32-DCI_EV_W){1'b0}}, mask};
      DCI_OFS_LIVE: rdMux = {26'h0, haltQ, keyPos, warnQ, invEnQ, latch};
      DCI_OFS_CTRL: rdMux = {31'h0, swStop};
      default: rdMux = 32'h0; // unmapped reads as zero
    endcase
  end

  // bus registers: one wait cycle on reads so read data comes from a flop
  // a write to an unmapped offset changes nothing
  always_comb
  begin
    next_rdPending = rdAccept;
    next_readdata = avs_readdata;
    next_mask = mask;
    next_swStop = swStop;
    if (rdAccept)
      next_readdata = rdMux;
    if (avs_write)
    begin
      if (avs_address == DCI_OFS_MASK)
        next_mask = avs_writedata[DCI_EV_W-1:0];
      if (avs_address == DCI_OFS_CTRL)
        next_swStop = avs_writedata[DCI_CT_SW_STOP];
    end
  end

  // writes never wait; a read waits exactly one cycle
  assign avs_waitrequest = rdAccept;

  // read data stands until the next read is taken
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      mask <= DCI_MASK_RST;
      swStop <= DCI_SW_STOP_RST;
      rdPending <= 1'b0;
      avs_readdata <= 32'h0;
    end
    else
    begin
      mask <= next_mask;
      swStop <= next_swStop;
      rdPending <= next_rdPending;
      avs_readdata <= next_readdata;
    end
  end

  // outputs; irq is a level and drops when software reads status or masks the pending bits
  assign hold_release_n = latch;
  assign inverter_enable = invEnQ;
  assign operator_warning = warnQ;
  assign host_halt = haltQ;
  assign irq = |(status & mask);
endmodule

// file: rtl/dci_pkg.sv
package dci_pkg;
  // register byte offsets on the avalon slave
  localparam logic [3:0] DCI_OFS_STATUS = 4'h0;
  localparam logic [3:0] DCI_OFS_MASK = 4'h4;
  localparam logic [3:0] DCI_OFS_LIVE = 4'h8;
  localparam logic [3:0] DCI_OFS_CTRL = 4'hc;
  // event bit positions, shared by status and mask
  localparam int DCI_EV_LATCH_SET = 0;
  localparam int DCI_EV_LATCH_CLR = 1;
  localparam int DCI_EV_WARN = 2;
  localparam int DCI_EV_INV_DROP = 3;
  localparam int DCI_EV_W = 4;
  // live register field positions
  localparam int DCI_LV_LATCH = 0;
  localparam int DCI_LV_INV_EN = 1;
  localparam int DCI_LV_WARN = 2;
  localparam int DCI_LV_MODE = 3;
  localparam int DCI_LV_HALT = 5;
  localparam int DCI_LV_W = 6;
  // control register fields
  localparam int DCI_CT_SW_STOP = 0;
  // reset values and synchroniser bundle width
  localparam logic [DCI_EV_W-1:0] DCI_MASK_RST = 4'h0;
  localparam logic DCI_LATCH_RST = 1'b1;
  localparam logic DCI_SW_STOP_RST = 1'b0;
  localparam int DCI_SYNC_W = 12;
  // key switch position decode
  typedef enum logic [1:0] {
    DCI_POS_LOCK = 2'b00,
    DCI_POS_SERVICE = 2'b01,
    DCI_POS_COMPUTER = 2'b10
  } dci_pos_t;
endpackage

// file: rtl/dci_sync.sv
`timescale 1ns/1ps
// two-flop synchroniser for a bundle of pin inputs
module dci_sync
  import dci_pkg::*;
#(
  parameter int W = DCI_SYNC_W
)
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [W-1:0] async_in,
  input wire logic [W-1:0] rst_val,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] stage1;
  logic [W-1:0] next_stage1;
  logic [W-1:0] next_sync_out;

  // first stage is read only by the second; reset value is a port so reset loads it via clocked mux
  always_comb
  begin
    next_stage1 = async_in;
    next_sync_out = stage1;
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      stage1 <= rst_val;
      sync_out <= rst_val;
    end
    else
    begin
      stage1 <= next_stage1;
      sync_out <= next_sync_out;
    end
  end
endmodule

// file: tb/dci_field_model.sv
`timescale 1ns/1ps
// field side: key switch, handpaddle, host and safety lines as plain levels
module dci_field_model (
  input logic core_clk,
  input logic [12:0] want,
  output logic [12:0] pins
);
  // power-up: lock position, nothing pressed, estop clear
  initial pins = 13'b11_1111_000_0111;
  // lines move just after an edge, like a host output register
  always @(posedge core_clk)
  begin
    pins <= want;
  end
endmodule

// file: tb/dci_sva.sv
`timescale 1ns/1ps
module dci_checker (
  input logic core_clk,
  input logic rst_n,
  input logic key_service_pos_n,
  input logic key_computer_pos_n,
  input logic pad_lock_n,
  input logic pad_unlock_n,
  input logic pad_forward_n,
  input logic pad_reverse_n,
  input logic host_lock_request,
  input logic host_unlatch_request,
  input logic host_watchdog_expired,
  input logic subsystem_reset,
  input logic estop_n,
  input logic brakes_released,
  input logic hold_pressure_sense,
  input logic hold_release_n,
  input logic inverter_enable,
  input logic operator_warning,
  input logic host_halt
);
  logic [12:0] pin, d1, d2, p;
  logic [2:0] up, next_up;
  assign pin = {key_service_pos_n, key_computer_pos_n, pad_lock_n, pad_unlock_n, pad_forward_n,
    pad_reverse_n, host_lock_request, host_unlatch_request, host_watchdog_expired, subsystem_reset,
    estop_n, brakes_released, hold_pressure_sense};
  // guard keeps checks off until no reset-time pins remain in the pipe
  always_comb next_up = (up == 3'h7) ? up : up + 3'h1;
  // p is aligned with the outputs: two sync flops plus output flop
  always_ff @(posedge core_clk)
  begin
    {p, d2, d1} <= {d2, d1, pin};
    up <= rst_n ? next_up : 3'h0;
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n || up != 3'h7);
  sequence s_lock_pos;
    p[12] == p[11];
  endsequence
  sequence s_host_set;
    !p[11] && p[12] && (p[6] || p[4]);
  endsequence
  sequence s_clear_ok;
    (!p[12] && p[11] && !p[9]) || (!p[11] && p[12] && p[5] && !p[4]);
  endsequence
  a_inv_base: assert property (inverter_enable |-> p[2] && p[1] && p[10])
    else $error("enable while interlocked");
  a_inv_host: assert property (inverter_enable && !p[11] |-> !p[6] && !p[4])
    else $error("enable against host");
  a_warn_level: assert property (operator_warning == (!(p[8] && p[7]) && !p[0]))
    else $error("warning wrong");
  a_lock_pos: assert property (s_lock_pos |-> hold_release_n && !inverter_enable)
    else $error("lock position not held");
  a_safety_set: assert property (!p[2] || p[3] || (!p[12] && !p[10]) |-> hold_release_n)
    else $error("latch not set");
  a_host_set: assert property (s_host_set |-> hold_release_n)
    else $error("host set missed");
  a_clear_cause: assert property ($fell(hold_release_n) |-> s_clear_ok)
    else $error("release without cause");
  a_halt_wdog: assert property (p[4] |-> host_halt)
    else $error("halt missing");
endmodule

// file: tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import dci_pkg::*;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [3:0] avs_address = 4'h0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata, q;
  logic avs_waitrequest, hold_release_n, inverter_enable, operator_warning, host_halt, irq;
  logic key_service_pos_n, key_computer_pos_n, pad_lock_n, pad_unlock_n, pad_forward_n, pad_reverse_n;
  logic host_lock_request, host_unlatch_request, host_watchdog_expired, subsystem_reset, estop_n;
  logic brakes_released, hold_pressure_sense;
  logic [12:0] want = 13'b11_1111_000_0111;
  int nErrors = 0;
  int checksDone = 0;
  always #4 core_clk = ~core_clk;
  dci_field_model u_far (.core_clk(core_clk), .want(want), .pins({key_service_pos_n, key_computer_pos_n,
    pad_lock_n, pad_unlock_n, pad_forward_n, pad_reverse_n, host_lock_request, host_unlatch_request,
    host_watchdog_expired, subsystem_reset, estop_n, brakes_released, hold_pressure_sense}));
  dome_clamp_interlock u_dome_clamp_interlock (
    .core_clk(core_clk), .rst_n(rst_n), .key_service_pos_n(key_service_pos_n),
    .key_computer_pos_n(key_computer_pos_n), .pad_lock_n(pad_lock_n), .pad_unlock_n(pad_unlock_n),
    .pad_forward_n(pad_forward_n), .pad_reverse_n(pad_reverse_n), .host_lock_request(host_lock_request),
    .host_unlatch_request(host_unlatch_request), .host_watchdog_expired(host_watchdog_expired),
    .subsystem_reset(subsystem_reset), .estop_n(estop_n), .brakes_released(brakes_released),
    .hold_pressure_sense(hold_pressure_sense), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .hold_release_n(hold_release_n), .inverter_enable(inverter_enable),
    .operator_warning(operator_warning), .host_halt(host_halt), .irq(irq));
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checksDone++;
    if (s !== e)
    begin
      nErrors++;
      $display("ERROR %0t: got %h expected %h", $time, s, e);
    end
  endtask
  // model flop, two sync flops, output flop, one spare edge
  task automatic step(input logic [12:0] v, input logic [3:0] e);
    want <= v;
    repeat (5) @(posedge core_clk);
    chk({28'h0, hold_release_n, inverter_enable, operator_warning, host_halt}, {28'h0, e});
  endtask
  // request held until waitrequest is seen low; idle edge after release
  task automatic acc(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    @(posedge core_clk);
    while (avs_waitrequest !== 1'b0 && n < 20)
    begin
      n++;
      @(posedge core_clk);
    end
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge core_clk);
    if (n == 20)
      chk(32'h1, 32'h0);
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checksDone, nErrors);
    if (nErrors == 0 && checksDone > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (8) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    acc(1'b1, DCI_OFS_MASK, 32'h1);
    acc(1'b0, DCI_OFS_MASK, 32'h0);
    chk(q, 32'h1); // mask readback
    acc(1'b0, 4'h2, 32'h0);
    chk(q, 32'h0); // unmapped reads zero
    step(13'b11_1111_000_0111, 4'b1000); // lock position
    acc(1'b0, DCI_OFS_STATUS, 32'h0);
    $display("test lock done");
    step(13'b01_1011_000_0111, 4'b0100); // pad unlock
    step(13'b01_1101_000_0110, 4'b0110); // forward, clamp engaged
    step(13'b01_0111_000_0111, 4'b1000); // pad lock
    chk(32'(irq), 32'h1); // unmasked set event
    acc(1'b0, DCI_OFS_STATUS, 32'h0);
    chk(q & 32'h1, 32'h1); // set event recorded
    chk(32'(irq), 32'h0); // cleared by read
    step(13'b01_1111_000_0111, 4'b1100); // button gone, latch holds
    step(13'b01_1011_000_1111, 4'b1100); // reset beats unlock
    step(13'b01_1011_000_0111, 4'b0100); // unlock again
    step(13'b01_1111_000_0101, 4'b0000); // brakes applied, latch holds
    step(13'b01_1111_000_0011, 4'b1000); // estop
    $display("test service done");
    step(13'b10_1111_011_0111, 4'b1001); // unlatch in watchdog
    step(13'b10_1111_010_0111, 4'b0100); // unlatch
    acc(1'b0, DCI_OFS_LIVE, 32'h0);
    chk(q, 32'h12); // live view, computer
    acc(1'b1, DCI_OFS_CTRL, 32'h1);
    step(13'b10_1111_010_0111, 4'b1001); // software stop
    acc(1'b1, DCI_OFS_CTRL, 32'h0);
    step(13'b10_1111_010_0111, 4'b0100); // stop withdrawn
    step(13'b10_1111_100_0111, 4'b1000); // host lock
    step(13'b10_1111_010_0111, 4'b0100); // unlatch
    step(13'b00_1111_010_0111, 4'b1000); // both key lines low
    $display("test computer done");
    wrap_up();
  end
  // whole run needs about a hundred edges
  initial
  begin
    repeat (3000) @(posedge core_clk);
    nErrors++;
    wrap_up();
  end
endmodule
bind dome_clamp_interlock dci_checker u_chk (
  .core_clk(core_clk), .rst_n(rst_n), .key_service_pos_n(key_service_pos_n),
  .key_computer_pos_n(key_computer_pos_n), .pad_lock_n(pad_lock_n), .pad_unlock_n(pad_unlock_n),
  .pad_forward_n(pad_forward_n), .pad_reverse_n(pad_reverse_n), .host_lock_request(host_lock_request),
  .host_unlatch_request(host_unlatch_request), .host_watchdog_expired(host_watchdog_expired),
  .subsystem_reset(subsystem_reset), .estop_n(estop_n), .brakes_released(brakes_released),
  .hold_pressure_sense(hold_pressure_sense), .hold_release_n(hold_release_n),
  .inverter_enable(inverter_enable), .operator_warning(operator_warning), .host_halt(host_halt));
